// >>> hdl/sba_arbiter.sv
`timescale 1ns/100ps
module sba_arbiter
(
  input  wire logic                   i_clock,
  input  wire logic                   i_resetn,
  input  wire logic [6:0]             i_req,
  input  wire sba_pkg::sba_cmd_t [6:0] i_slot_cmd,
  output      logic [6:0]             o_grant,
  output      logic [6:0]             o_drive_en,
  output      logic                   o_busy,
  output      sba_pkg::sba_cmd_t      o_bus,
  output      sba_pkg::sba_rsp_t      o_rsp
);

  // -------------------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_meta_next;
  logic rst_n_reg;
  logic rst_n_next;

  // Release ripples through both stages
  always_comb
  begin
    rst_meta_next = 1'b1;
    rst_n_next    = rst_meta_reg;
  end

  // Two-stage release of the asynchronous reset
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= rst_meta_next;
      rst_n_reg    <= rst_n_next;
    end
  end

  // -------------------------------------------------------------------------
  // Priority pick
  // -------------------------------------------------------------------------
  logic [6:0] req_above;
  logic [6:0] win_onehot;
  logic [2:0] win_idx;
  logic       any_req;

  // Per slot: any request further right blocks this one
  genvar s;
  generate
    for (s = 0; s < sba_pkg::SLOTS; s++)
    begin : g_pick
      assign req_above[s]  = |(i_req >> (s + 1));
      assign win_onehot[s] = i_req[s] && !req_above[s];
    end
  endgenerate

  // Any slot asking for the bus
  assign any_req = |i_req;

  // Index of the single winning slot
  always_comb
  begin
    win_idx = 3'h0;
    for (int i = 0; i < sba_pkg::SLOTS; i++)
      if (win_onehot[i])
        win_idx = i[2:0];
  end

  // -------------------------------------------------------------------------
  // Grant state machine
  // -------------------------------------------------------------------------
  sba_pkg::sba_arb_state_t state_reg;
  sba_pkg::sba_arb_state_t state_next;
  logic [6:0]              grant_reg;
  logic [6:0]              grant_next;
  logic [2:0]              owner_reg;
  logic [2:0]              owner_next;
  logic                    owner_req;

  // Request line of the slot now holding the bus
  assign owner_req = i_req[owner_reg];

  // Next grant, owner and state
  always_comb
  begin
    state_next = state_reg;
    grant_next = grant_reg;
    owner_next = owner_reg;
    case (state_reg)
      sba_pkg::ARB_IDLE:
      begin
        if (any_req)
        begin
          state_next = sba_pkg::ARB_OWNED;
          owner_next = win_idx;
          grant_next = win_onehot;
        end
      end
      sba_pkg::ARB_OWNED:
      begin
        // Owner dropping its request ends the tenure; one idle cycle
        // follows so two grants never overlap
        if (!owner_req)
        begin
          state_next = sba_pkg::ARB_IDLE;
          grant_next = sba_pkg::GRANT_RST;
        end
      end
      default:
      begin
        state_next = sba_pkg::ARB_IDLE;
        grant_next = sba_pkg::GRANT_RST;
        owner_next = 3'h0;
      end
    endcase
  end

  // Grant state registers
  always_ff @(posedge i_clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      state_reg <= sba_pkg::ARB_IDLE;
      grant_reg <= sba_pkg::GRANT_RST;
      owner_reg <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      grant_reg <= grant_next;
      owner_reg <= owner_next;
    end
  end

  // -------------------------------------------------------------------------
  // Shared bus drive
  // -------------------------------------------------------------------------
  // Owner's command, registered, and per-slot drive enables
  sba_pkg::sba_cmd_t       bus_reg;
  sba_pkg::sba_cmd_t       bus_next;
  sba_pkg::sba_cmd_t [6:0] slot_masked;
  logic [6:0]              drive_reg;
  logic [6:0]              drive_next;

  // Per slot: a command passes only while its slot keeps the grant
  generate
    for (s = 0; s < sba_pkg::SLOTS; s++)
    begin : g_mask
      assign slot_masked[s] = grant_next[s] ? i_slot_cmd[s]
                                            : sba_pkg::CMD_IDLE;
    end
  endgenerate

  // Only the granted slot reaches the shared address and command lines
  always_comb
  begin
    bus_next   = sba_pkg::CMD_IDLE;
    drive_next = grant_next;
    if (state_reg == sba_pkg::ARB_OWNED)
      for (int i = 0; i < sba_pkg::SLOTS; i++)
        bus_next = sba_pkg::sba_cmd_t'(bus_next | slot_masked[i]);
  end

  // Shared bus and drive enable registers
  always_ff @(posedge i_clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      bus_reg   <= sba_pkg::CMD_IDLE;
      drive_reg <= sba_pkg::GRANT_RST;
    end
    else
    begin
      bus_reg   <= bus_next;
      drive_reg <= drive_next;
    end
  end

  // -------------------------------------------------------------------------
  // Local slave registers
  // -------------------------------------------------------------------------
  logic local_slave;

  // Local board answers only while another slot holds the bus
  assign local_slave = !drive_reg[sba_pkg::LOCAL_SLOT];

  // Register file reached through the shared bus
  sba_slave_regs u_regs
  (
    .i_clock  (i_clock),
    .i_rst_n  (rst_n_reg),
    .i_enable (local_slave),
    .i_bus    (bus_reg),
    .o_rsp    (o_rsp)
  );

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  // Every output straight from a flop
  assign o_grant    = grant_reg;
  assign o_drive_en = drive_reg;
  assign o_busy     = state_reg;
  assign o_bus      = bus_reg;

endmodule // sba_arbiter

// >>> hdl/sba_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants and types for the system bus arbiter
// ---------------------------------------------------------------------------
package sba_pkg;

  // Slots on the processor segment; higher index sits further right
  localparam int unsigned SLOTS      = 7;
  localparam int unsigned SLOT_W     = 3;
  // Slot of the board that holds this arbiter and its slave registers
  localparam logic [2:0]  LOCAL_SLOT = 3'h0;

  // Bus widths
  localparam int unsigned ADR_W = 16;
  localparam int unsigned DAT_W = 16;

  // Firmware address window shared by all card-cage boards
  localparam logic [15:0] WIN_LO = 16'hf000;
  localparam logic [15:0] WIN_HI = 16'hf7ff;

  // Base of this board's I/O registers inside the window
  localparam logic [15:0] REG_BASE  = 16'hf100;
  localparam int unsigned REG_NUM   = 8;
  localparam int unsigned REG_IDX_W = 3;
  // Register index sits in address bits [3:1]; [15:4] pick the board
  localparam int unsigned IDX_LSB   = 1;
  localparam int unsigned BASE_LSB  = 4;

  // Values after reset
  localparam logic [15:0] REG_RST   = 16'h0000;
  localparam logic [6:0]  GRANT_RST = 7'h00;

  // One bus cycle as offered by a slot or as seen on the shared bus
  typedef struct packed {
    logic [15:0] adr;
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
  } sba_cmd_t;

  localparam sba_cmd_t CMD_IDLE = '{adr: 16'h0000, rd: 1'b0, wr: 1'b0,
                                    wdata: 16'h0000};

  // Answer of a slave to a read or write
  typedef struct packed {
    logic        ack;
    logic        oe;
    logic [15:0] rdata;
  } sba_rsp_t;

  localparam sba_rsp_t RSP_IDLE = '{ack: 1'b0, oe: 1'b0, rdata: 16'h0000};

  // Arbiter states
  typedef enum logic [0:0] {
    ARB_IDLE  = 1'b0,
    ARB_OWNED = 1'b1
  } sba_arb_state_t;

endpackage

// >>> hdl/sba_slave_regs.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// I/O registers that answer the current bus master
// ---------------------------------------------------------------------------
module sba_slave_regs
(
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_enable,
  input  wire sba_pkg::sba_cmd_t i_bus,
  output      sba_pkg::sba_rsp_t o_rsp
);

  logic [15:0]       regs_reg [sba_pkg::REG_NUM];
  logic [15:0]       regs_next[sba_pkg::REG_NUM];
  sba_pkg::sba_rsp_t rsp_reg;
  sba_pkg::sba_rsp_t rsp_next;
  logic              in_win;
  logic              hit;
  logic [2:0]        idx;

  // Address decode within the shared window
  assign in_win = (i_bus.adr >= sba_pkg::WIN_LO) &&
                  (i_bus.adr <= sba_pkg::WIN_HI);
  assign hit    = in_win && i_enable &&
                  (i_bus.adr[15:sba_pkg::BASE_LSB] ==
                   sba_pkg::REG_BASE[15:sba_pkg::BASE_LSB]);
  assign idx    = i_bus.adr[sba_pkg::IDX_LSB +: sba_pkg::REG_IDX_W];

  // Per-register write capture
  genvar g;
  generate
    for (g = 0; g < sba_pkg::REG_NUM; g++)
    begin : g_reg
      always_comb
      begin
        regs_next[g] = regs_reg[g];
        if (hit && i_bus.wr && idx == 3'(g))
          regs_next[g] = i_bus.wdata;
      end

      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
          regs_reg[g] <= sba_pkg::REG_RST;
        else
          regs_reg[g] <= regs_next[g];
      end
    end
  endgenerate

  // Read data, drive enable and acknowledge
  always_comb
  begin
    rsp_next = sba_pkg::RSP_IDLE;
    if (hit && (i_bus.rd || i_bus.wr))
      rsp_next.ack = 1'b1;
    if (hit && i_bus.rd)
    begin
      rsp_next.oe    = 1'b1;
      rsp_next.rdata = regs_reg[idx];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rsp_reg <= sba_pkg::RSP_IDLE;
    else
      rsp_reg <= rsp_next;
  end

  assign o_rsp = rsp_reg;

endmodule // sba_slave_regs

// >>> sim/sba_arbiter_props.sv
`timescale 1ns/100ps
// ----------------------------------------
// Arbiter and slave checker
// ----------------------------------------
module sba_arbiter_props
(
  input wire logic                    i_clock,
  input wire logic                    i_resetn,
  input wire logic [6:0]              i_req,
  input wire sba_pkg::sba_cmd_t [6:0] i_slot_cmd,
  input wire logic [6:0]              o_grant,
  input wire logic [6:0]              o_drive_en,
  input wire logic                    o_busy,
  input wire sba_pkg::sba_cmd_t       o_bus,
  input wire sba_pkg::sba_rsp_t       o_rsp
);
  sba_pkg::sba_cmd_t sel;
  logic              hit;
  // Command of the granted slot
  always_comb
  begin
    sel = sba_pkg::CMD_IDLE;
    for (int i = 0; i < 7; i++)
      if (o_grant[i])
        sel = i_slot_cmd[i];
  end
  // Bus cycle aimed at the local registers
  assign hit = (o_bus.rd | o_bus.wr)
    && o_bus.adr >= sba_pkg::WIN_LO && o_bus.adr <= sba_pkg::WIN_HI
    && !o_drive_en[sba_pkg::LOCAL_SLOT]
    && o_bus.adr[15:4] == sba_pkg::REG_BASE[15:4];
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  chk_one_owner: assert property ($onehot0(o_grant))
    else $error("several grants");
  chk_grant_hold: assert property (
    o_busy && (i_req & o_grant) != 7'h00 |=> $stable(o_grant))
    else $error("grant lost");
  chk_release_bus: assert property (
    o_busy && (i_req & o_grant) == 7'h00 |=> !o_busy)
    else $error("bus kept");
  chk_pick_highest: assert property ($rose(o_busy) |->
    {1'b0, $past(i_req)} < {o_grant, 1'b0} && (o_grant & $past(i_req)) != 0)
    else $error("wrong winner");
  chk_drive_owner: assert property (
    o_drive_en == o_grant) else $error("drive without grant");
  chk_idle_bus: assert property (
    !o_busy |-> o_bus == sba_pkg::CMD_IDLE)
    else $error("bus driven while idle");
  chk_bus_source: assert property (
    o_busy && $past(o_busy) |-> o_bus == $past(sel))
    else $error("bus from wrong slot");
  chk_slave_ack: assert property (
    o_rsp.ack == $past(hit)) else $error("ack mismatch");
  chk_read_drive: assert property (
    o_rsp.oe == ($past(hit) && $past(o_bus.rd)))
    else $error("read drive mismatch");
  // Main scenarios
  cover property ($rose(o_busy));
  cover property (o_rsp.ack && o_rsp.oe);
  cover property (o_rsp.ack && !o_rsp.oe);
  cover property (o_busy && o_drive_en[0]);
endmodule // sba_arbiter_props

bind sba_arbiter sba_arbiter_props sba_arbiter_props_inst (.i_clock(i_clock),
  .i_resetn(i_resetn), .i_req(i_req), .i_slot_cmd(i_slot_cmd),
  .o_grant(o_grant), .o_drive_en(o_drive_en), .o_busy(o_busy),
  .o_bus(o_bus), .o_rsp(o_rsp));

// >>> sim/sba_boards.sv
`timescale 1ns/100ps
// ----------------------------------------
// Slot boards sharing the bus
// ----------------------------------------
module sba_boards
(
  input  wire logic                    i_clock,
  input  wire logic [6:0]              i_want,
  input  wire sba_pkg::sba_cmd_t       i_cmd,
  input  wire logic [6:0]              i_grant,
  output      logic [6:0]              o_req,
  output      sba_pkg::sba_cmd_t [6:0] o_cmd
);
  sba_pkg::sba_cmd_t [6:0] last_reg = '0;
  // Request held by the board until it is done
  assign o_req = i_want;
  // Drive once granted, else inverted last value
  always_comb
    for (int s = 0; s < 7; s++)
      o_cmd[s] = i_grant[s] ? i_cmd : ~last_reg[s];
  // Remember last driven command
  always_ff @(posedge i_clock)
    for (int s = 0; s < 7; s++)
      if (i_grant[s])
        last_reg[s] <= i_cmd;
endmodule // sba_boards

// >>> sim/tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// Arbiter testbench
// ----------------------------------------
module tb;
  logic                    clk = 0;
  logic                    rstn = 0;
  logic [6:0]              want = 0;
  sba_pkg::sba_cmd_t       cmd = sba_pkg::CMD_IDLE;
  logic [6:0]              req, grant, drv;
  logic                    busy;
  sba_pkg::sba_cmd_t [6:0] scmd;
  sba_pkg::sba_cmd_t       bus;
  sba_pkg::sba_rsp_t       rsp;
  logic [15:0]             mem [8];
  logic [15:0]             rd_val;
  int                      miscompares = 0, n_checks = 0, acks, cyc = 0;
  sba_arbiter sba_arbiter_inst (.i_clock(clk), .i_resetn(rstn), .i_req(req),
    .i_slot_cmd(scmd), .o_grant(grant), .o_drive_en(drv), .o_busy(busy),
    .o_bus(bus), .o_rsp(rsp));
  sba_boards sba_boards_inst (.i_clock(clk), .i_want(want), .i_cmd(cmd),
    .i_grant(drv), .o_req(req), .o_cmd(scmd));
  // Clock and hang limit
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      conclude();
    end
  end
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [6:0] top_bit(logic [6:0] w);
    top_bit = 7'h00;
    for (int i = 0; i < 7; i++)
      if (w[i])
        top_bit = 7'h01 << i;
  endfunction
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // Serve every wish, highest slot first
  task automatic arb(logic [6:0] w);
    logic [6:0] exp;
    int n;
    want = w;
    while (want != 0)
    begin
      exp = top_bit(want);
      for (n = 0; busy !== 1'b1 && n < 20; n++) step();
      cmp("grant", {9'h000, exp}, {9'h000, grant});
      want = want & ~exp;
      step();
      cmp("busy", 16'h0000, {15'h0000, busy});
    end
  endtask
  // One bus cycle from slot s, held three cycles
  task automatic access(int s, logic [15:0] a, logic r, logic [15:0] d);
    int n;
    cmd = '{adr: a, rd: r, wr: !r, wdata: d};
    rd_val = 16'hxxxx;
    acks = 0;
    want[s] = 1'b1;
    for (n = 0; grant[s] !== 1'b1 && n < 20; n++) step();
    repeat (3)
    begin
      step();
      if (rsp.ack === 1'b1) acks++;
      if (rsp.oe === 1'b1) rd_val = rsp.rdata;
    end
    want[s] = 1'b0;
    repeat (3) step();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(86));
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    arb(7'h7f);
    arb(7'h01);
    repeat (10) arb(7'($urandom()) | 7'h01);
    $display("arbitration test done");
    for (int k = 0; k < 8; k++)
    begin
      mem[k] = 16'($urandom());
      access(1 + $urandom() % 6, {12'hf10, 3'(k), 1'($urandom())}, 0,
             mem[k]);
      cmp("write ack", 16'h0001, 16'(acks > 0));
    end
    for (int k = 0; k < 8; k++)
    begin
      access(1 + $urandom() % 6, {12'hf10, 3'(k), 1'b0}, 1, 16'h0000);
      cmp("read data", mem[k], rd_val);
    end
    $display("register test done");
    access(0, 16'hf102, 0, 16'hdead);
    cmp("own ack", 16'h0000, 16'(acks));
    access(2, 16'hf802, 0, 16'hbeef);
    cmp("far ack", 16'h0000, 16'(acks));
    access(3, 16'hf202, 0, 16'h5a5a);
    cmp("other ack", 16'h0000, 16'(acks));
    access(4, 16'hf103, 1, 16'h0000);
    cmp("kept data", mem[1], rd_val);
    $display("refusal test done");
    conclude();
  end
endmodule // tb
